// ==== rtl/hcs_cfg.svh ====
// hcs_cfg.svh: constants of the host control service decoder
`ifndef HCS_CFG_SVH
`define HCS_CFG_SVH
// request codes seen from the host
`define HCS_OP_SYSSTAT 8'h0D
`define HCS_OP_STOP 8'h0E
`define HCS_OP_EXIT 8'h0F
`define HCS_OP_CFG 8'h18
`define HCS_OP_CFG_MASK 8'hF8
`define HCS_OP_REGWR 8'h28
`define HCS_OP_REGRD 8'h38
`define HCS_OP_REG_MASK 8'hFC
// configure request bit positions
`define HCS_CFG_BIT_P 2
`define HCS_CFG_BIT_C 1
`define HCS_CFG_BIT_M 0
// indication codes sent to the host
`define HCS_IND_SYSSTAT 8'h4B
`define HCS_IND_STOP 8'h2B
`define HCS_IND_RESET 8'h03
`define HCS_IND_CFG_LO 3'h1
`define HCS_IND_FRAME_END 8'hCB
// timing
`define HCS_CLK_HZ 50000000
`define HCS_TICK_HZ 1000000
`define HCS_SILENCE_MS 2.6
// crc
`define HCS_CRC_INIT 16'hFFFF
`define HCS_CRC_POLY 16'h1021
// software register port
`define HCS_ADDR_STATUS 2'h0
`define HCS_ADDR_CTRL 2'h1
`define HCS_CTRL_BUSY 0
`define HCS_CTRL_AA 1
`endif

// ==== rtl/hcs_crc16.sv ====
// hcs_crc16.sv: byte-wide crc-16-ccitt accumulator
`timescale 1ns/1ps
`default_nettype none
`include "hcs_cfg.svh"
module hcs_crc16 (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // control and data
   input wire logic clr,
   input wire logic en,
   input wire logic [7:0] data,
   // result
   output logic [15:0] crc
);
   import hcs_pkg::*;
   typedef struct packed {
      logic [15:0] crc;
   } hcs_crc_state_s;
   hcs_crc_state_s s_q;
   hcs_crc_state_s s_d;
   logic [15:0] chain [0:8];

   // one shift stage per data bit, msb first
   assign chain[0] = s_q.crc;
   for (genvar i = 0; i < 8; i++) begin : g_bit
      logic fb;
      assign fb = chain[i][15] ^ data[7-i];
      assign chain[i+1] = {chain[i][14:0], 1'b0} ^ (fb ? `HCS_CRC_POLY : 16'h0000);
   end

   // next state
   always_comb begin
      s_d = s_q;
      if (clr) begin
         s_d.crc = `HCS_CRC_INIT;
      end else if (en) begin
         s_d.crc = chain[8];
      end
   end

   // state register
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '{crc: `HCS_CRC_INIT};
      end else begin
         s_q <= s_d;
      end
   end

   assign crc = s_q.crc;

   a_crc_restart: assert property (
      @(posedge sys_clk) disable iff (!arst_n) clr |=> crc == `HCS_CRC_INIT)
      else $error("crc not restarted after clear");
endmodule : hcs_crc16
`default_nettype wire

// ==== rtl/hcs_pkg.sv ====
// hcs_pkg.sv: types of the host control service decoder
`default_nettype none
package hcs_pkg;
   typedef enum logic [3:0] {
      HCS_M_PWRUP = 4'h1,
      HCS_M_SYNC = 4'h2,
      HCS_M_STOP = 4'h4,
      HCS_M_NORMAL = 4'h8
   } hcs_mode_e;
   typedef enum logic [5:0] {
      HCS_FE_IDLE = 6'h01,
      HCS_FE_CRC_HI = 6'h02,
      HCS_FE_CRC_LO = 6'h04,
      HCS_FE_MARK = 6'h08,
      HCS_FE_STATE = 6'h10,
      HCS_FE_SILENT = 6'h20
   } hcs_fe_e;
   typedef struct packed {
      logic linear_reg_ok;
      logic dcdc2_ok;
      logic bus_voltage_ok;
      logic tank_cap_ok;
      logic osc_freq_ok;
      logic thermal_warning_flag;
   } hcs_mon_s;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } hcs_byte_s;
   typedef struct packed {
      logic autopoll;
      logic crc;
      logic marker;
   } hcs_feat_s;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [1:0] addr;
      logic [7:0] wdata;
   } hcs_sw_req_s;
endpackage : hcs_pkg
`default_nettype wire

// ==== rtl/hcs_silence.sv ====
// hcs_silence.sv: silence timer built on a microsecond tick divider
`timescale 1ns/1ps
`default_nettype none
module hcs_silence #(
   parameter int TICK_CYC = 50,
   parameter int TICKS = 2600
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // control
   input wire logic start,
   // status
   output logic busy
);
   import hcs_pkg::*;
   localparam int DW = $clog2(TICK_CYC + 1);
   localparam int CW = $clog2(TICKS + 1);
   typedef struct packed {
      logic [DW-1:0] div;
      logic [CW-1:0] cnt;
      logic busy;
   } hcs_sil_state_s;
   hcs_sil_state_s s_q;
   hcs_sil_state_s s_d;
   logic tick;

   if (TICK_CYC < 1 || TICKS < 1) begin : g_chk
      $error("silence timer counts must be at least one");
   end

   // tick pulse once per divider period
   assign tick = s_q.busy && (s_q.div == DW'(TICK_CYC - 1));

   // next state
   always_comb begin
      s_d = s_q;
      if (start) begin
         s_d = '{div: '0, cnt: '0, busy: 1'b1};
      end else if (s_q.busy) begin
         s_d.div = tick ? '0 : s_q.div + 1'b1;
         if (tick) begin
            s_d.cnt = s_q.cnt + 1'b1;
            s_d.busy = (s_q.cnt != CW'(TICKS - 1));
         end
      end
   end

   // state register
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '{div: '0, cnt: '0, busy: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign busy = s_q.busy;

   a_sil_start: assert property (
      @(posedge sys_clk) disable iff (!arst_n) start |=> busy && s_q.cnt == '0)
      else $error("silence did not start");
endmodule : hcs_silence
`default_nettype wire

// ==== rtl/hcs_top.sv ====
// hcs_top.sv: host control service decoder with frame end handling
`timescale 1ns/1ps
`default_nettype none
`include "hcs_cfg.svh"
module hcs_top #(
   parameter int AW = 2,
   parameter int TICK_CYC = `HCS_CLK_HZ / `HCS_TICK_HZ,
   parameter int SILENCE_TICKS = int'(`HCS_SILENCE_MS * 1000.0)
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // monitors and line state
   input wire hcs_pkg::hcs_mon_s mon,
   input wire logic bus_idle,
   input wire logic pwr_ready,
   input wire logic sync_done,
   // bytes from the host
   input wire hcs_pkg::hcs_byte_s rx,
   output logic rx_ready,
   // bytes to the host
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready,
   // bytes received from the bus
   input wire hcs_pkg::hcs_byte_s bus_byte,
   output logic bus_ready,
   input wire logic frame_done,
   input wire logic [7:0] frame_state,
   // feature and alert outputs
   output logic autopoll_active,
   output logic crc_active,
   output logic marker_active,
   output logic autoack_active,
   output logic save_alert_n,
   // software register port
   input wire hcs_pkg::hcs_sw_req_s sw,
   output logic [7:0] sw_rdata
);
   import hcs_pkg::*;
   localparam int REG_CNT = 2 ** AW;
   typedef struct packed {
      hcs_mode_e mode;
      hcs_fe_e fe;
      hcs_feat_s feat;
      logic [2:0] cfg_req;
      logic cfg_pend;
      logic ack_pend;
      logic wr_pend;
      logic [AW-1:0] wr_addr;
      logic [REG_CNT-1:0][7:0] regs;
      logic [1:0] resp_n;
      logic [7:0] resp0;
      logic [7:0] resp1;
      logic tx_v;
      logic [7:0] tx_b;
      logic dup;
      logic [15:0] crc_snap;
      logic [7:0] fstate;
      logic [1:0] ctrl;
      logic [7:0] rdata;
      logic alert_n;
   } hcs_top_state_s;
   localparam hcs_top_state_s S_RST = '{mode: HCS_M_PWRUP, fe: HCS_FE_IDLE, default: '0};

   hcs_top_state_s s_q;
   hcs_top_state_s s_d;
   logic take;
   logic free;
   logic bus_take;
   logic sil_start;
   logic sil_busy;
   logic [15:0] crc_now;
   logic [7:0] stat_byte;
   logic [AW-1:0] req_addr;

   if (AW < 1 || AW > 2) begin : g_chk
      $error("register address must be one or two bits");
   end

   // status mode code of the operating state
   function automatic logic [1:0] hcs_code(input hcs_mode_e m);
      unique case (m)
         HCS_M_PWRUP: hcs_code = 2'h0;
         HCS_M_SYNC: hcs_code = 2'h1;
         HCS_M_STOP: hcs_code = 2'h2;
         HCS_M_NORMAL: hcs_code = 2'h3;
         default: hcs_code = 2'h0;
      endcase
   endfunction : hcs_code

   // handshakes toward host and bus source
   assign rx_ready = (s_q.resp_n == 2'h0) && !s_q.cfg_pend;
   assign take = rx.valid && rx_ready;
   assign free = (!s_q.tx_v || tx_ready) && (s_q.fe != HCS_FE_SILENT);
   assign bus_ready = free && (s_q.resp_n == 2'h0) && (s_q.fe == HCS_FE_IDLE)
      && !s_q.dup && !frame_done;
   assign bus_take = bus_byte.valid && bus_ready;
   assign req_addr = rx.data[AW-1:0];

   // status byte from live monitors and current mode
   assign stat_byte = {mon.linear_reg_ok, mon.dcdc2_ok, mon.bus_voltage_ok,
      mon.tank_cap_ok, mon.osc_freq_ok, mon.thermal_warning_flag,
      hcs_code(s_q.mode)};

   // next state of the whole decoder
   always_comb begin
      s_d = s_q;
      s_d.rdata = 8'h00;
      // save alert from the live status bits
      s_d.alert_n = !((~&stat_byte[7:3]) || stat_byte[2]);
      // software port
      if (sw.wr && sw.addr == `HCS_ADDR_CTRL) begin
         s_d.ctrl = sw.wdata[1:0];
      end
      if (sw.rd) begin
         unique case (sw.addr)
            `HCS_ADDR_STATUS: s_d.rdata = {hcs_code(s_q.mode), s_q.cfg_pend, s_q.feat,
               s_q.ctrl[`HCS_CTRL_AA], s_q.ctrl[`HCS_CTRL_BUSY]};
            `HCS_ADDR_CTRL: s_d.rdata = {6'h00, s_q.ctrl};
            default: s_d.rdata = 8'h00;
         endcase
      end
      // host request decode
      if (take && s_q.wr_pend) begin
         s_d.regs[s_q.wr_addr] = rx.data;
         s_d.wr_pend = 1'b0;
      end else if (take) begin
         if (rx.data == `HCS_OP_SYSSTAT) begin
            s_d.resp0 = `HCS_IND_SYSSTAT;
            s_d.resp1 = stat_byte;
            s_d.resp_n = 2'h2;
         end else if (rx.data == `HCS_OP_STOP) begin
            s_d.mode = HCS_M_STOP;
            s_d.ack_pend = 1'b0;
            s_d.resp0 = `HCS_IND_STOP;
            s_d.resp_n = 2'h1;
         end else if (rx.data == `HCS_OP_EXIT) begin
            if (s_q.mode == HCS_M_STOP) begin
               s_d.mode = HCS_M_SYNC;
               s_d.ack_pend = 1'b1;
            end
         end else if ((rx.data & `HCS_OP_CFG_MASK) == `HCS_OP_CFG) begin
            s_d.cfg_req = rx.data[2:0];
            s_d.cfg_pend = 1'b1;
         end else if ((rx.data & `HCS_OP_REG_MASK) == `HCS_OP_REGWR) begin
            s_d.wr_pend = 1'b1;
            s_d.wr_addr = req_addr;
         end else if ((rx.data & `HCS_OP_REG_MASK) == `HCS_OP_REGRD) begin
            s_d.resp0 = s_q.regs[req_addr];
            s_d.resp_n = 2'h1;
         end
      end
      // operating state progress
      unique case (s_q.mode)
         HCS_M_PWRUP: begin
            // a stop request taken in this cycle must not be overridden
            if (pwr_ready && s_d.mode == HCS_M_PWRUP) begin
               s_d.mode = HCS_M_SYNC;
            end
         end
         HCS_M_SYNC: begin
            if (sync_done && !take && s_q.resp_n == 2'h0) begin
               s_d.mode = HCS_M_NORMAL;
               if (s_q.ack_pend) begin
                  s_d.resp0 = `HCS_IND_RESET;
                  s_d.resp_n = 2'h1;
                  s_d.ack_pend = 1'b0;
               end
            end
         end
         HCS_M_STOP: begin
         end
         HCS_M_NORMAL: begin
         end
         default: s_d.mode = HCS_M_PWRUP;
      endcase
      // feature activation, only setting bits, confirmed at once
      if (s_q.cfg_pend && s_q.resp_n == 2'h0 && (bus_idle || s_q.mode != HCS_M_NORMAL)) begin
         s_d.feat.autopoll = s_q.feat.autopoll | s_q.cfg_req[`HCS_CFG_BIT_P];
         s_d.feat.crc = s_q.feat.crc | s_q.cfg_req[`HCS_CFG_BIT_C];
         s_d.feat.marker = s_q.feat.marker | s_q.cfg_req[`HCS_CFG_BIT_M];
         s_d.resp0 = {s_q.ctrl[`HCS_CTRL_BUSY], s_q.ctrl[`HCS_CTRL_AA], s_d.feat,
            `HCS_IND_CFG_LO};
         s_d.resp_n = 2'h1;
         s_d.cfg_pend = 1'b0;
      end
      // transmit register and frame end sequence
      if (s_q.tx_v && tx_ready) begin
         s_d.tx_v = 1'b0;
      end
      if (s_q.fe == HCS_FE_IDLE && frame_done) begin
         s_d.crc_snap = crc_now;
         s_d.fstate = frame_state;
         if (s_q.feat.crc) begin
            s_d.fe = HCS_FE_CRC_HI;
         end else if (s_q.feat.marker) begin
            s_d.fe = HCS_FE_MARK;
         end else begin
            s_d.fe = HCS_FE_SILENT;
         end
      end else if (s_q.fe == HCS_FE_SILENT) begin
         if (!sil_busy) begin
            s_d.fe = HCS_FE_IDLE;
         end
      end else if (free && s_q.resp_n != 2'h0) begin
         s_d.tx_v = 1'b1;
         s_d.tx_b = s_q.resp0;
         s_d.resp0 = s_q.resp1;
         s_d.resp_n = s_q.resp_n - 2'h1;
      end else if (free && s_q.dup) begin
         s_d.tx_v = 1'b1;
         s_d.tx_b = `HCS_IND_FRAME_END;
         s_d.dup = 1'b0;
      end else if (free) begin
         unique case (s_q.fe)
            HCS_FE_IDLE: begin
               if (bus_take) begin
                  s_d.tx_v = 1'b1;
                  s_d.tx_b = bus_byte.data;
                  s_d.dup = s_q.feat.marker && (bus_byte.data == `HCS_IND_FRAME_END);
               end
            end
            HCS_FE_CRC_HI: begin
               s_d.tx_v = 1'b1;
               s_d.tx_b = s_q.crc_snap[15:8];
               s_d.fe = HCS_FE_CRC_LO;
            end
            HCS_FE_CRC_LO: begin
               s_d.tx_v = 1'b1;
               s_d.tx_b = s_q.crc_snap[7:0];
               s_d.fe = s_q.feat.marker ? HCS_FE_MARK : HCS_FE_SILENT;
            end
            HCS_FE_MARK: begin
               s_d.tx_v = 1'b1;
               s_d.tx_b = `HCS_IND_FRAME_END;
               s_d.fe = HCS_FE_STATE;
            end
            HCS_FE_STATE: begin
               s_d.tx_v = 1'b1;
               s_d.tx_b = s_q.fstate;
               s_d.fe = HCS_FE_IDLE;
            end
            HCS_FE_SILENT: begin
            end
            default: s_d.fe = HCS_FE_IDLE;
         endcase
      end
   end

   // silence starts on entry to the silent phase
   assign sil_start = (s_d.fe == HCS_FE_SILENT) && (s_q.fe != HCS_FE_SILENT);

   // state register
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= S_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // crc over every byte forwarded from the bus
   hcs_crc16 u_crc (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .clr(s_q.fe == HCS_FE_IDLE && frame_done),
      .en(bus_take),
      .data(bus_byte.data),
      .crc(crc_now)
   );

   // quiet line after a frame when no marker is used
   hcs_silence #(
      .TICK_CYC(TICK_CYC),
      .TICKS(SILENCE_TICKS)
   ) u_sil (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .start(sil_start),
      .busy(sil_busy)
   );

   // outputs
   assign tx_valid = s_q.tx_v;
   assign tx_data = s_q.tx_b;
   assign autopoll_active = s_q.feat.autopoll;
   assign crc_active = s_q.feat.crc;
   assign marker_active = s_q.feat.marker;
   assign autoack_active = s_q.ctrl[`HCS_CTRL_AA];
   assign save_alert_n = s_q.alert_n;
   assign sw_rdata = s_q.rdata;

   a_save_alert: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      arst_n |=> save_alert_n == !((~&$past(stat_byte[7:3])) || $past(stat_byte[2])))
      else $error("save alert does not follow status bits");
   a_stop_entry: assert property (
      @(posedge sys_clk) disable iff (!arst_n) take && !s_q.wr_pend && rx.data == `HCS_OP_STOP
      |=> s_q.mode == HCS_M_STOP && s_q.resp0 == `HCS_IND_STOP ##1 tx_data == `HCS_IND_STOP)
      else $error("stop request not confirmed");
   a_exit_sync: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      $rose(s_q.mode == HCS_M_NORMAL) |-> $past(s_q.ack_pend) == (s_q.resp0 == `HCS_IND_RESET))
      else $error("exit acknowledge not tied to sync to normal");
   a_feat_sticky: assert property (
      @(posedge sys_clk) disable iff (!arst_n) (s_q.feat & $past(s_q.feat)) == $past(s_q.feat))
      else $error("feature cleared without reset");
   a_cfg_moment: assert property (
      @(posedge sys_clk) disable iff (!arst_n) $fell(s_q.cfg_pend)
      |-> $past(bus_idle || s_q.mode != HCS_M_NORMAL) && s_q.resp0[7:3] ==
      {s_q.ctrl[`HCS_CTRL_BUSY], s_q.ctrl[`HCS_CTRL_AA], s_q.feat})
      else $error("configure not confirmed at activation");
   a_silent_line: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      s_q.fe == HCS_FE_SILENT && $past(s_q.fe == HCS_FE_SILENT) |-> !tx_valid || $past(tx_valid))
      else $error("byte started during silence");
   a_marker_seq: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      s_q.fe == HCS_FE_MARK && free && s_q.resp_n == 2'h0 && !s_q.dup
      |=> tx_data == `HCS_IND_FRAME_END && s_q.fe == HCS_FE_STATE)
      else $error("end marker not sent");
   a_reg_read: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      take && !s_q.wr_pend && (rx.data & `HCS_OP_REG_MASK) == `HCS_OP_REGRD
      |=> s_q.resp0 == $past(s_q.regs[req_addr]) && s_q.resp_n == 2'h1)
      else $error("register read returned wrong byte");
   a_crc_order: assert property (
      @(posedge sys_clk) disable iff (!arst_n) s_q.fe == HCS_FE_IDLE && frame_done && s_q.feat.crc
      |=> s_q.fe == HCS_FE_CRC_HI && s_q.crc_snap == $past(crc_now))
      else $error("crc not appended");
endmodule : hcs_top
`default_nettype wire

// ==== tb/hcs_host_model.sv ====
// hcs_host_model.sv: host controller model on the byte link of the decoder
`timescale 1ns/1ps
`default_nettype none
module hcs_host_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // stall control from the bench
   input wire logic slow,
   // byte link
   output var hcs_pkg::hcs_byte_s rx,
   input wire logic rx_ready,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready
);
   import hcs_pkg::*;
   logic [7:0] got[$];

   // collect bytes from the device; when slow, accept only every other cycle
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_ready <= 1'b1;
      end else begin
         if (tx_valid && tx_ready) got.push_back(tx_data);
         tx_ready <= slow ? ~tx_ready : 1'b1;
      end
   end

   // one request byte, held until taken; idle data shows inverted bits
   task send(input logic [7:0] b);
      @(posedge sys_clk);
      rx <= '{valid: 1'b1, data: b};
      do @(posedge sys_clk); while (!rx_ready);
      rx <= '{valid: 1'b0, data: ~b};
   endtask : send

   // idle link at time zero
   initial rx = '0;
endmodule : hcs_host_model
`default_nettype wire

// ==== tb/testbench.sv ====
// testbench.sv: self-checking bench of the host control service decoder
`timescale 1ns/1ps
`default_nettype none
`include "hcs_cfg.svh"
module testbench;
   import hcs_pkg::*;
   localparam int TC = 2;
   localparam int ST = 3;
   logic sys_clk, arst_n, bus_idle, pwr_ready, sync_done, frame_done, slow;
   logic rx_ready, tx_valid, tx_ready, bus_ready, autopoll_active, crc_active;
   logic marker_active, autoack_active, save_alert_n;
   logic [7:0] frame_state, tx_data, sw_rdata;
   logic [5:0] mons[4] = '{6'h3E, 6'h3F, 6'h1E, 6'h3C};
   hcs_mon_s mon;
   hcs_byte_s rx, bus_byte;
   hcs_sw_req_s sw;
   int fails, checks_done, cyc;

   // short silence counts keep the run brief
   hcs_top #(.TICK_CYC(TC), .SILENCE_TICKS(ST)) i_hcs_top (
      .sys_clk, .arst_n, .mon, .bus_idle, .pwr_ready, .sync_done, .rx, .rx_ready,
      .tx_valid, .tx_data, .tx_ready, .bus_byte, .bus_ready, .frame_done, .frame_state,
      .autopoll_active, .crc_active, .marker_active, .autoack_active, .save_alert_n,
      .sw, .sw_rdata
   );
   hcs_host_model i_hcs_host_model (
      .sys_clk, .arst_n, .slow, .rx, .rx_ready, .tx_valid, .tx_data, .tx_ready
   );

   // 50 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fails++;
         results();
      end
   end

   task results;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results

   task chk8(input logic [7:0] a, input logic [7:0] e, input string m);
      checks_done++;
      if (a !== e) begin
         fails++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, a, e);
      end
   endtask : chk8

   task chk1(input logic a, input logic e, input string m);
      chk8({7'h00, a}, {7'h00, e}, m);
   endtask : chk1

   // next byte the host received must be e
   task txe(input logic [7:0] e);
      int n;
      n = 0;
      while (i_hcs_host_model.got.size() == 0 && n < 300) begin
         @(posedge sys_clk);
         n++;
      end
      chk1(i_hcs_host_model.got.size() != 0, 1'b1, "missing byte");
      if (i_hcs_host_model.got.size() != 0) chk8(i_hcs_host_model.got.pop_front(), e, "tx");
   endtask : txe

   task none;
      repeat (20) @(posedge sys_clk);
      chk1(i_hcs_host_model.got.size() == 0, 1'b1, "extra byte");
   endtask : none

   task feat(input logic [2:0] e);
      chk8({5'h00, autopoll_active, crc_active, marker_active}, {5'h00, e}, "features");
   endtask : feat

   // status request and its two-byte answer
   task stat(input logic [1:0] md);
      i_hcs_host_model.send(`HCS_OP_SYSSTAT);
      txe(`HCS_IND_SYSSTAT);
      txe({mon, md});
   endtask : stat

   task swr(input logic [1:0] a, input logic [7:0] d);
      sw <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge sys_clk);
      sw <= '0;
      @(posedge sys_clk);
   endtask : swr

   task swq(input logic [1:0] a, input logic [7:0] e);
      sw <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge sys_clk);
      sw <= '0;
      @(negedge sys_clk);
      chk8(sw_rdata, e, "sw read");
      @(negedge sys_clk);
      chk8(sw_rdata, 8'h00, "sw idle");
      @(posedge sys_clk);
   endtask : swq

   function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `HCS_CRC_POLY : 16'h0000);
      end
      return c;
   endfunction : crc16

   // one bus frame, then its end handling as the features dictate
   task frame(input logic [7:0] b[$], input logic [7:0] st, input logic c, input logic m);
      logic [15:0] r;
      int n;
      r = `HCS_CRC_INIT;
      n = 0;
      foreach (b[i]) begin
         @(posedge sys_clk);
         bus_byte <= '{valid: 1'b1, data: b[i]};
         do @(posedge sys_clk); while (!bus_ready);
         bus_byte <= '{valid: 1'b0, data: ~b[i]};
         r = crc16(r, b[i]);
      end
      @(posedge sys_clk);
      frame_done <= 1'b1;
      frame_state <= st;
      @(posedge sys_clk);
      frame_done <= 1'b0;
      frame_state <= ~st;
      repeat (40) begin
         @(posedge sys_clk);
         if (!bus_ready) n++;
      end
      if (!m) chk1(n >= ST * TC, 1'b1, "silence");
      foreach (b[i]) begin
         txe(b[i]);
         if (m && b[i] == `HCS_IND_FRAME_END) txe(b[i]);
      end
      if (c) txe(r[15:8]);
      if (c) txe(r[7:0]);
      if (m) txe(`HCS_IND_FRAME_END);
      if (m) txe(st);
      none();
   endtask : frame

   // main sequence
   initial begin
      arst_n = 1'b0;
      mon = 6'h3E;
      bus_idle = 1'b1;
      pwr_ready = 1'b0;
      sync_done = 1'b0;
      frame_done = 1'b0;
      frame_state = 8'h00;
      bus_byte = '0;
      sw = '0;
      slow = 1'b0;
      repeat (3) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      feat(3'b000);
      foreach (mons[i]) begin
         mon <= mons[i];
         repeat (2) @(posedge sys_clk);
         chk1(save_alert_n, &mons[i][5:1] & ~mons[i][0], "save alert");
         stat(2'b00);
      end
      mon <= 6'h3E;
      pwr_ready <= 1'b1;
      repeat (3) @(posedge sys_clk);
      stat(2'b01);
      i_hcs_host_model.send(`HCS_OP_STOP);
      txe(`HCS_IND_STOP);
      stat(2'b10);
      // register services in stop, each after the previous one ended, host stalling
      slow <= 1'b1;
      for (int a = 0; a < 4; a++) begin
         i_hcs_host_model.send(8'(`HCS_OP_REGWR | a));
         i_hcs_host_model.send(8'(8'h5A + a * 17));
      end
      for (int a = 0; a < 4; a++) begin
         i_hcs_host_model.send(8'(`HCS_OP_REGRD | a));
         txe(8'(8'h5A + a * 17));
      end
      slow <= 1'b0;
      i_hcs_host_model.send(`HCS_OP_EXIT);
      none();
      stat(2'b01);
      sync_done <= 1'b1;
      txe(`HCS_IND_RESET);
      stat(2'b11);
      i_hcs_host_model.send(`HCS_OP_EXIT);
      none();
      frame('{8'hA5}, 8'h00, 1'b0, 1'b0);
      bus_idle <= 1'b0;
      i_hcs_host_model.send(8'h1C);
      none();
      feat(3'b000);
      bus_idle <= 1'b1;
      txe(8'h21);
      feat(3'b100);
      i_hcs_host_model.send(8'h1A);
      txe(8'h31);
      frame('{8'h12, 8'h34}, 8'h00, 1'b1, 1'b0);
      i_hcs_host_model.send(8'h19);
      txe(8'h39);
      frame('{8'hCB, 8'h77}, 8'h0C, 1'b1, 1'b1);
      i_hcs_host_model.send(`HCS_OP_CFG);
      txe(8'h39);
      feat(3'b111);
      swr(`HCS_ADDR_CTRL, 8'h03);
      swq(`HCS_ADDR_CTRL, 8'h03);
      swq(2'h2, 8'h00);
      swq(`HCS_ADDR_STATUS, 8'hDF);
      i_hcs_host_model.send(`HCS_OP_CFG);
      txe(8'hF9);
      chk1(autoack_active, 1'b1, "autoack");
      // second reset in mid-run clears every feature
      arst_n <= 1'b0;
      @(negedge sys_clk);
      feat(3'b000);
      chk1(save_alert_n, 1'b0, "alert in reset");
      @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      feat(3'b000);
      results();
   end
endmodule : testbench
`default_nettype wire
